//--- core/iocn_top.sv
// Contract
// R01: Open-drain bit set: pin only drives low, floats when high.
// R02: Software sets direction to input on pins used as analog inputs.
// R03: Analog pin configuration resets to zero, all shared pins analog.
// R04: Port read returns zero for every pin configured as analog.
// R05: Software waits one cycle between port write and port read.
// R06: Change detection works with clocks stopped and raises an interrupt.
// R07: Up to 21 pins selectable as change notification sources.
// R08: Two interrupt-enable and two pull-up-enable registers control notification.
// R09: Enable bit set lets that pin's change interrupt; clear masks it.
// R10: Pull-up enable bit connects weak pull-up; clearing disconnects it.
// R11: Software keeps pull-ups off on pins driven as digital outputs.
// R12: Five-bit timer clock select: codes 0..25 pick pin, 31 grounds.
// R13: Change found by comparing synchronised level with previous sample.
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ns

module iocn_top (
    input  wire logic                        clk_i,      // 20 MHz clock
    input  wire logic                        rst_i,      // Sync reset, high
    // Wishbone classic slave
    input  wire logic                        wb_cyc_i,   // Cycle
    input  wire logic                        wb_stb_i,   // Strobe
    input  wire logic                        wb_we_i,    // Write enable
    input  wire logic [7:0]                  wb_adr_i,   // Byte address
    input  wire logic [3:0]                  wb_sel_i,   // Byte lanes
    input  wire logic [31:0]                 wb_dat_i,   // Write data
    output logic      [31:0]                 wb_dat_o,   // Read data
    output logic                             wb_ack_o,   // Acknowledge
    // Port pins
    input  wire logic [iocn_pkg::PORT_W-1:0] pad_i,      // Pin levels
    output logic      [iocn_pkg::PORT_W-1:0] pad_o,      // Pin drive value
    output logic      [iocn_pkg::PORT_W-1:0] pad_oe_o,   // Pin drive enable
    // Change notification pins
    input  wire logic [iocn_pkg::CN_W-1:0]   cn_pin_i,   // Notify inputs
    output logic      [iocn_pkg::CN_W-1:0]   cn_pullup_o,// Weak pull-ups on
    output logic                             cn_wake_o,  // Wake request
    // Remappable pins to timer clocks
    input  wire logic [iocn_pkg::RP_W-1:0]   rp_i,       // Remappable pins
    output logic                             tmr4_clk_o, // Timer 4 ext clock
    output logic                             tmr5_clk_o, // Timer 5 ext clock
    output logic                             irq_o       // Interrupt, high
);
    import iocn_pkg::*;

    // Pick a remappable pin by select code; unused codes read as ground
    function automatic logic pin_select(input logic [SEL_W-1:0] sel,
                                        input logic [RP_W-1:0]  pins);
        logic res;
        res = 1'b0;
        if (sel <= SEL_MAX_PIN) begin
            res = pins[sel];
        end
        return res;
    endfunction

    // Software visible registers
    logic [PORT_W-1:0]  pin_direction_bits_q;
    logic [PORT_W-1:0]  output_latch_q;
    logic [PORT_W-1:0]  open_drain_ctrl_q;
    logic [PORT_W-1:0]  analog_pin_config_q;
    logic [CN_LO_W-1:0] change_irq_enable_lo_q;
    logic [CN_HI_W-1:0] change_irq_enable_hi_q;
    logic [CN_LO_W-1:0] pullup_enable_lo_q;
    logic [CN_HI_W-1:0] pullup_enable_hi_q;
    logic [15:0]        timer45_clock_input_select_q;
    logic [ST_W-1:0]    irq_status_q;
    logic [ST_W-1:0]    irq_mask_q;
    logic [31:0]        rd_data_q;
    logic               ack_q;
    logic               tmr4_clk_q;
    logic               tmr5_clk_q;

    // Bus decode
    logic               bus_req;
    logic               wr_take;
    logic               rd_take;
    logic [5:0]         reg_idx;
    logic [15:0]        wr_lo;
    logic [15:0]        lane_mask;
    logic [31:0]        rd_data_d;
    logic               hit;

    // Change detector side
    logic [CN_W-1:0]    cn_enable;
    logic [CN_W-1:0]    cn_level;
    logic               cn_change;
    logic [ST_W-1:0]    irq_event;
    logic [ST_W-1:0]    irq_clear;
    logic [SEL_W-1:0]   t4_sel;
    logic [SEL_W-1:0]   t5_sel;
    logic [PORT_W-1:0]  port_read;

    // A request is live while cyc and stb are both high
    assign bus_req   = wb_cyc_i & wb_stb_i;
    assign reg_idx   = wb_adr_i[7:2];
    // Writes land on the edge where the master sees ack
    assign wr_take   = bus_req & ack_q & wb_we_i;
    assign rd_take   = bus_req & ~ack_q & ~wb_we_i;
    assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Byte-lane merge for 16-bit registers; upper lanes hold nothing
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] neu,
                                          input logic [15:0] msk);
        merge = (old & ~msk) | (neu & msk);
    endfunction

    assign wr_lo = wb_dat_i[15:0];

    // Analog pins read low whatever level sits on them
    assign port_read = pad_i & analog_pin_config_q; // R04

    // Read mux; unmapped words answer with zero
    always_comb begin
        rd_data_d = 32'h0000_0000;
        hit       = 1'b1;
        case (reg_idx)
            IDX_DIR:     rd_data_d[15:0] = pin_direction_bits_q;
            IDX_LATCH:   rd_data_d[15:0] = output_latch_q;
            IDX_PORT:    rd_data_d[15:0] = port_read; // R04
            IDX_ODC:     rd_data_d[15:0] = open_drain_ctrl_q;
            IDX_ANALOG:  rd_data_d[15:0] = analog_pin_config_q;
            IDX_CNEN_LO: rd_data_d[15:0] = change_irq_enable_lo_q; // R08
            IDX_CNEN_HI: rd_data_d[CN_HI_W-1:0] = change_irq_enable_hi_q;
            IDX_PU_LO:   rd_data_d[15:0] = pullup_enable_lo_q; // R08
            IDX_PU_HI:   rd_data_d[CN_HI_W-1:0] = pullup_enable_hi_q;
            IDX_TSEL:    rd_data_d[15:0] = timer45_clock_input_select_q;
            IDX_STATUS:  rd_data_d[ST_W-1:0] = irq_status_q;
            IDX_MASK:    rd_data_d[ST_W-1:0] = irq_mask_q;
            default:     hit = 1'b0;
        endcase
    end

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    // Read data is captured when ack rises and held until the next read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_q <= 32'h0000_0000;
        end else if (rd_take) begin
            rd_data_q <= hit ? rd_data_d : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_data_q;

    // Port control registers; pins come up as inputs and analog
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_direction_bits_q <= DIR_RST;
            output_latch_q       <= 16'h0000;
            open_drain_ctrl_q    <= 16'h0000;
            analog_pin_config_q  <= ANALOG_RST; // R03
        end else if (wr_take) begin
            if (reg_idx == IDX_DIR)
                pin_direction_bits_q <= merge(pin_direction_bits_q,
                                              wr_lo, lane_mask);
            if (reg_idx == IDX_LATCH)
                output_latch_q <= merge(output_latch_q, wr_lo, lane_mask);
            if (reg_idx == IDX_ODC)
                open_drain_ctrl_q <= merge(open_drain_ctrl_q, wr_lo,
                                           lane_mask);
            if (reg_idx == IDX_ANALOG)
                analog_pin_config_q <= merge(analog_pin_config_q, wr_lo,
                                             lane_mask);
        end
    end

    // Change notification enables and pull-ups, two words each
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            change_irq_enable_lo_q <= 16'h0000;
            change_irq_enable_hi_q <= '0;
            pullup_enable_lo_q     <= 16'h0000;
            pullup_enable_hi_q     <= '0;
        end else if (wr_take) begin
            if (reg_idx == IDX_CNEN_LO)
                change_irq_enable_lo_q <= merge(change_irq_enable_lo_q,
                                                wr_lo, lane_mask); // R08
            if (reg_idx == IDX_CNEN_HI && wb_sel_i[0])
                change_irq_enable_hi_q <= wb_dat_i[CN_HI_W-1:0];
            if (reg_idx == IDX_PU_LO)
                pullup_enable_lo_q <= merge(pullup_enable_lo_q, wr_lo,
                                            lane_mask); // R08
            if (reg_idx == IDX_PU_HI && wb_sel_i[0])
                pullup_enable_hi_q <= wb_dat_i[CN_HI_W-1:0];
        end
    end

    // Timer clock select; both fields reset to the ground code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer45_clock_input_select_q <= TSEL_RST;
        end else if (wr_take && reg_idx == IDX_TSEL) begin
            timer45_clock_input_select_q <=
                merge(timer45_clock_input_select_q, wr_lo,
                      lane_mask & 16'h1f1f);
        end
    end

    // Push-pull drives both levels; open-drain only pulls low
    generate
        for (genvar i = 0; i < PORT_W; i++) begin : g_pad
            assign pad_o[i]    = open_drain_ctrl_q[i] ? 1'b0
                                                      : output_latch_q[i];
            assign pad_oe_o[i] = ~pin_direction_bits_q[i] &
                                 (~open_drain_ctrl_q[i] |
                                  ~output_latch_q[i]); // R01
        end
    endgenerate

    // Pull-ups follow their enables directly, no pin-mode qualifier
    assign cn_pullup_o = {pullup_enable_hi_q, pullup_enable_lo_q}; // R10
    assign cn_enable   = {change_irq_enable_hi_q,
                          change_irq_enable_lo_q}; // R07 R09

    // Synchroniser and comparator for the notification pins
    iocn_change_det u_det (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .pin_i    (cn_pin_i),
        .en_i     (cn_enable),
        .lvl_o    (cn_level),
        .change_o (cn_change),
        .wake_o   (cn_wake_o)
    );

    // Sticky status: a new event beats a write-one-to-clear
    assign irq_event = cn_change ? 1'b1 : 1'b0; // R06
    assign irq_clear = (wr_take && reg_idx == IDX_STATUS && wb_sel_i[0])
                       ? wb_dat_i[ST_W-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_q <= '0;
            irq_mask_q   <= '0;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clear) | irq_event; // R06
            if (wr_take && reg_idx == IDX_MASK && wb_sel_i[0])
                irq_mask_q <= wb_dat_i[ST_W-1:0];
        end
    end

    assign irq_o = |(irq_status_q & irq_mask_q); // R06

    // Route the selected pins to the timers, registered against glitches
    assign t4_sel = timer45_clock_input_select_q[T4_SEL_LSB +: SEL_W];
    assign t5_sel = timer45_clock_input_select_q[T5_SEL_LSB +: SEL_W];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr4_clk_q <= 1'b0;
            tmr5_clk_q <= 1'b0;
        end else begin
            tmr4_clk_q <= pin_select(t4_sel, rp_i); // R12
            tmr5_clk_q <= pin_select(t5_sel, rp_i); // R12
        end
    end

    // Max timer clock is half the system clock
    assign tmr4_clk_o = tmr4_clk_q;
    assign tmr5_clk_o = tmr5_clk_q;

    // Rule checks; sticky status and bus timing are the likely hazards
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    od_no_high_a: assert property ( // R01
        (pad_oe_o & open_drain_ctrl_q & ~output_latch_q) ==
        (~pin_direction_bits_q & open_drain_ctrl_q & ~output_latch_q)
        && (pad_oe_o & pad_o & open_drain_ctrl_q) == '0)
        else $error("open-drain pin drove high");

    analog_reset_a: assert property ( // R03
        $past(rst_i) |-> analog_pin_config_q == ANALOG_RST)
        else $error("analog config not zero after reset");

    port_analog_a: assert property ( // R04
        rd_take && reg_idx == IDX_PORT |=>
        (wb_dat_o[15:0] & ~$past(analog_pin_config_q)) == 16'h0000)
        else $error("analog pin read nonzero");

    change_sticky_a: assert property ( // R06
        cn_change |=> irq_status_q[ST_CHANGE] ##1
        (irq_status_q[ST_CHANGE] || $past(irq_clear[ST_CHANGE])))
        else $error("change event lost");

    enable_hi_w_a: assert property ( // R07
        rd_take && reg_idx == IDX_CNEN_HI |=> wb_dat_o[31:CN_HI_W] == '0)
        else $error("enable word wider than pin count");

    irq_level_a: assert property ( // R09
        irq_status_q[ST_CHANGE] && irq_mask_q[ST_CHANGE] |-> irq_o)
        else $error("unmasked status without interrupt");

    pullup_write_a: assert property ( // R10
        wr_take && reg_idx == IDX_PU_LO && wb_sel_i == 4'hf |=>
        cn_pullup_o[15:0] == $past(wb_dat_i[15:0]))
        else $error("pull-up write not applied");

    tsel_ground_a: assert property ( // R12
        t5_sel == SEL_GROUND |=> !tmr5_clk_o)
        else $error("grounded timer select not low");

    tsel_route_a: assert property ( // R12
        t4_sel <= SEL_MAX_PIN |=> tmr4_clk_o == $past(rp_i[t4_sel]))
        else $error("timer clock not routed from pin");

    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    status_clear_a: assert property ( // R06
        irq_clear[ST_CHANGE] && !irq_event[ST_CHANGE] |=>
        !irq_status_q[ST_CHANGE])
        else $error("status bit not cleared by write");

    set_wins_a: assert property ( // R06
        irq_event[ST_CHANGE] && irq_clear[ST_CHANGE] |=>
        irq_status_q[ST_CHANGE])
        else $error("clear beat a new change event");

    input_no_drive_a: assert property ( // R02
        (pad_oe_o & pin_direction_bits_q) == '0)
        else $error("input pin driven");

    pullup_hi_write_a: assert property ( // R10
        wr_take && reg_idx == IDX_PU_HI && wb_sel_i[0] |=>
        cn_pullup_o[CN_W-1:CN_LO_W] == $past(wb_dat_i[CN_HI_W-1:0]))
        else $error("upper pull-up write not applied");

    // Main scenarios the bench should reach
    change_irq_c: cover property (
        cn_change ##1 irq_status_q[ST_CHANGE] && irq_o);

    tsel_pin_c: cover property (
        t4_sel == 5'h03 && rp_i[3] ##1 tmr4_clk_o);

    od_low_c: cover property (
        open_drain_ctrl_q[0] && pad_oe_o[0]);

    wake_c: cover property (
        cn_wake_o ##1 cn_wake_o);

    analog_read_c: cover property (
        rd_take && reg_idx == IDX_PORT && analog_pin_config_q == 16'h00ff);

endmodule

//--- core/iocn_pkg.sv
package iocn_pkg;

    // Pin counts of the port
    localparam int PORT_W     = 16;
    localparam int CN_W       = 21;
    localparam int CN_LO_W    = 16;
    localparam int CN_HI_W    = CN_W - CN_LO_W;
    localparam int RP_W       = 26;
    localparam int SEL_W      = 5;

    // Word indices of the register map (byte address = index * 4)
    localparam logic [5:0] IDX_DIR      = 6'h00;
    localparam logic [5:0] IDX_LATCH    = 6'h01;
    localparam logic [5:0] IDX_PORT     = 6'h02;
    localparam logic [5:0] IDX_ODC      = 6'h03;
    localparam logic [5:0] IDX_ANALOG   = 6'h04;
    localparam logic [5:0] IDX_CNEN_LO  = 6'h05;
    localparam logic [5:0] IDX_CNEN_HI  = 6'h06;
    localparam logic [5:0] IDX_PU_LO    = 6'h07;
    localparam logic [5:0] IDX_PU_HI    = 6'h08;
    localparam logic [5:0] IDX_TSEL     = 6'h09;
    localparam logic [5:0] IDX_STATUS   = 6'h0a;
    localparam logic [5:0] IDX_MASK     = 6'h0b;

    // Values after reset
    localparam logic [15:0] DIR_RST     = 16'hffff;
    localparam logic [15:0] ANALOG_RST  = 16'h0000;
    localparam logic [15:0] TSEL_RST    = 16'h1f1f;

    // Field positions of the timer clock select register
    localparam int T4_SEL_LSB  = 0;
    localparam int T5_SEL_LSB  = 8;

    // Select codes
    localparam logic [4:0] SEL_MAX_PIN = 5'h19;
    localparam logic [4:0] SEL_GROUND  = 5'h1f;

    // Status bit positions
    localparam int ST_CHANGE = 0;
    localparam int ST_W      = 1;

endpackage

//--- core/iocn_change_det.sv
`timescale 1ns/1ns

module iocn_change_det (
    input  wire logic                      clk_i,    // System clock
    input  wire logic                      rst_i,    // Sync reset, high
    input  wire logic [iocn_pkg::CN_W-1:0] pin_i,    // Notification pins
    input  wire logic [iocn_pkg::CN_W-1:0] en_i,     // Per-pin enables
    output logic      [iocn_pkg::CN_W-1:0] lvl_o,    // Synchronised levels
    output logic                           change_o, // Enabled pin moved
    output logic                           wake_o    // Clockless change
);
    import iocn_pkg::*;

    logic [CN_W-1:0] sync1_q;
    logic [CN_W-1:0] sync2_q;
    logic [CN_W-1:0] prev_q;

    // Two-stage synchroniser plus previous sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q; // R13
        end
    end

    // Compare synchronised level with the last one, masked per pin
    assign lvl_o    = sync2_q;
    assign change_o = |((sync2_q ^ prev_q) & en_i); // R13 R09

    // Raw pins against the held sample: works with the clock stopped
    assign wake_o   = |((pin_i ^ prev_q) & en_i); // R06

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    pin_change_a: assert property ( // R13
        (|((pin_i ^ $past(pin_i)) & en_i)) ##1 $stable(en_i)
        ##1 $stable(en_i) |-> change_o)
        else $error("enabled pin change not detected");

    masked_pin_a: assert property ( // R09
        (en_i == '0) |-> !change_o && !wake_o)
        else $error("masked pins raised a change");

endmodule

//--- verification/iocn_pin_model.sv
`timescale 1ns/1ns

module iocn_pin_model (
    input  wire logic                        clk_i,     // System clock
    input  wire logic [iocn_pkg::PORT_W-1:0] dev_val_i, // Device drive
    input  wire logic [iocn_pkg::PORT_W-1:0] dev_oe_i,  // Device enable
    input  wire logic [iocn_pkg::PORT_W-1:0] ext_val_i, // Board drive
    input  wire logic [iocn_pkg::PORT_W-1:0] ext_oe_i,  // Board enable
    input  wire logic [iocn_pkg::CN_W-1:0]   pullup_i,  // Weak pull-ups
    input  wire logic [iocn_pkg::CN_W-1:0]   cn_val_i,  // Switch levels
    input  wire logic [iocn_pkg::CN_W-1:0]   cn_oe_i,   // Switch driving
    output logic      [iocn_pkg::PORT_W-1:0] pad_o,     // Pad levels
    output logic      [iocn_pkg::CN_W-1:0]   cn_o       // Notify levels
);
    import iocn_pkg::*;

    logic toggle_q = 1'b0;

    // A floating line holds no value, so show one that keeps moving
    always_ff @(posedge clk_i) begin
        toggle_q <= ~toggle_q;
    end

    // Board resistor lifts released pads, as open-drain needs
    assign pad_o = (dev_oe_i & dev_val_i)
                 | (~dev_oe_i & ext_oe_i & ext_val_i)
                 | (~dev_oe_i & ~ext_oe_i);

    // Released notify line sits on its weak pull-up, else wanders
    assign cn_o = (cn_oe_i & cn_val_i)
                | (~cn_oe_i & pullup_i)
                | (~cn_oe_i & ~pullup_i & {CN_W{toggle_q}});
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ns

module testbench;
    import iocn_pkg::*;

    logic          clk_i    = 1'b0;
    logic          rst_i    = 1'b1;
    logic          wb_cyc_i = 1'b0;
    logic          wb_stb_i = 1'b0;
    logic          wb_we_i  = 1'b0;
    logic [7:0]    wb_adr_i = 8'h00;
    logic [3:0]    wb_sel_i = 4'hf;
    logic [31:0]   wb_dat_i = 32'h0;
    logic [31:0]   wb_dat_o;
    logic          wb_ack_o;
    logic [15:0]   pad_i, pad_o, pad_oe_o;
    logic [15:0]   ext_val  = 16'h0;
    logic [15:0]   ext_oe   = 16'hffff;
    logic [20:0]   cn_pin_i, cn_pullup_o;
    logic [20:0]   cn_val   = 21'h0;
    logic [20:0]   cn_oe    = 21'h1fffff;
    logic          cn_wake_o, tmr4_clk_o, tmr5_clk_o, irq_o;
    logic [25:0]   rp_i     = 26'h0;
    int            error_cnt   = 0;
    int            comparisons = 0;

    always #25 clk_i = ~clk_i;

    iocn_top iocn_top_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_i(pad_i),
        .pad_o(pad_o), .pad_oe_o(pad_oe_o), .cn_pin_i(cn_pin_i),
        .cn_pullup_o(cn_pullup_o), .cn_wake_o(cn_wake_o), .rp_i(rp_i),
        .tmr4_clk_o(tmr4_clk_o), .tmr5_clk_o(tmr5_clk_o), .irq_o(irq_o));

    iocn_pin_model iocn_pin_model_inst (.clk_i(clk_i),
        .dev_val_i(pad_o), .dev_oe_i(pad_oe_o), .ext_val_i(ext_val),
        .ext_oe_i(ext_oe), .pullup_i(cn_pullup_o), .cn_val_i(cn_val),
        .cn_oe_i(cn_oe), .pad_o(pad_i), .cn_o(cn_pin_i));

    task automatic report_and_stop();
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One classic cycle; entered just after an edge, leaves cyc low
    task automatic wb(input logic we, input logic [5:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= wd;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH bus ack expected 1 seen %b", wb_ack_o);
            report_and_stop();
        end
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] x;
        wb(1'b1, idx, d, x);
    endtask

    task automatic rdc(input string name, input logic [5:0] idx,
                       input logic [31:0] exp);
        logic [31:0] x;
        wb(1'b0, idx, 32'h0, x);
        chk(name, x, exp);
    endtask

    task automatic test_reset();
        chk("oe reset", {16'h0, pad_oe_o}, 32'h0);
        rdc("dir", IDX_DIR, {16'h0, DIR_RST});
        rdc("analog", IDX_ANALOG, 32'h0);
        rdc("tsel", IDX_TSEL, {16'h0, TSEL_RST});
        wr(6'h3f, 32'hffff_ffff);
        rdc("unmapped", 6'h3f, 32'h0);
        rdc("status", IDX_STATUS, 32'h0);
    endtask

    // Pins stay inputs from reset while analog
    task automatic test_analog();
        ext_val <= 16'ha5a5;
        rdc("port analog", IDX_PORT, 32'h0);
        wr(IDX_ANALOG, 32'h00ff);
        rdc("port mixed", IDX_PORT, 32'h00a5);
        wr(IDX_ANALOG, 32'hffff);
        rdc("port digital", IDX_PORT, 32'ha5a5);
    endtask

    // Bus idle cycle gives the gap between write and read
    task automatic test_output();
        ext_oe <= 16'h0;
        wr(IDX_LATCH, 32'h5a5a);
        wr(IDX_DIR, 32'h0);
        rdc("port driven", IDX_PORT, 32'h5a5a);
        chk("oe push", {16'h0, pad_oe_o}, 32'hffff);
        wr(IDX_ODC, 32'h00ff);
        chk("oe drain", {16'h0, pad_oe_o}, 32'hffa5);
        chk("drain low", {16'h0, pad_o & pad_oe_o & 16'hff}, 32'h0);
        rdc("port drain", IDX_PORT, 32'h5a5a);
        wr(IDX_LATCH, 32'h0);
        chk("oe sink", {16'h0, pad_oe_o}, 32'hffff);
        rdc("port sink", IDX_PORT, 32'h0);
        wr(IDX_DIR, 32'hffff);
        wr(IDX_ODC, 32'h0);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_o !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            n++;
        end
        if (irq_o !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH irq wait expected 1 seen %b", irq_o);
            report_and_stop();
        end
    endtask

    task automatic test_change();
        wr(IDX_MASK, 32'h1);
        wr(IDX_CNEN_LO, 32'h0008);
        wr(IDX_CNEN_HI, 32'h0010);
        rdc("en lo", IDX_CNEN_LO, 32'h0008);
        rdc("en hi", IDX_CNEN_HI, 32'h0010);
        cn_val <= 21'h000020;
        @(posedge clk_i);
        chk("wake masked", {31'h0, cn_wake_o}, 32'h0);
        repeat (8) @(posedge clk_i);
        rdc("masked pin", IDX_STATUS, 32'h0);
        cn_val <= 21'h000028;
        @(posedge clk_i);
        chk("wake", {31'h0, cn_wake_o}, 32'h1);
        wait_irq();
        chk("irq", {31'h0, irq_o}, 32'h1);
        rdc("status set", IDX_STATUS, 32'h1);
        wr(IDX_STATUS, 32'h1);
        rdc("status clr", IDX_STATUS, 32'h0);
        chk("irq clr", {31'h0, irq_o}, 32'h0);
        chk("wake idle", {31'h0, cn_wake_o}, 32'h0);
        wr(IDX_MASK, 32'h0);
        cn_val <= 21'h100028;
        repeat (8) @(posedge clk_i);
        rdc("top pin", IDX_STATUS, 32'h1);
        chk("irq masked", {31'h0, irq_o}, 32'h0);
        wr(IDX_MASK, 32'h1);
        chk("irq unmask", {31'h0, irq_o}, 32'h1);
        wr(IDX_STATUS, 32'h1);
        chk("irq done", {31'h0, irq_o}, 32'h0);
    endtask

    // Port pins all inputs here, so pull-ups may go on
    task automatic test_pullup();
        wr(IDX_PU_LO, 32'h8001);
        wr(IDX_PU_HI, 32'h0010);
        chk("pullups", {11'h0, cn_pullup_o}, 32'h0010_8001);
        rdc("pu hi", IDX_PU_HI, 32'h0010);
        wr(IDX_PU_LO, 32'h0);
        wr(IDX_PU_HI, 32'h0);
        chk("pullups off", {11'h0, cn_pullup_o}, 32'h0);
    endtask

    task automatic test_timer();
        logic [4:0]  c4, c5;
        logic [25:0] pat;
        for (int c = 0; c < 32; c++) begin
            if (c > 26 && c < 31) continue;
            c4 = 5'(c);
            c5 = (c > 25) ? SEL_GROUND : 5'(25 - c);
            pat = (c > 25) ? 26'h3ffffff : (26'h1 << c);
            rp_i <= pat;
            wr(IDX_TSEL, {19'h0, c5, 3'h0, c4});
            repeat (2) @(posedge clk_i);
            chk("tmr4", {31'h0, tmr4_clk_o}, {31'h0, c < 26});
            chk("tmr5", {31'h0, tmr5_clk_o}, 32'h0);
            rp_i <= ~pat;
            repeat (2) @(posedge clk_i);
            chk("tmr4 inv", {31'h0, tmr4_clk_o}, 32'h0);
            chk("tmr5 inv", {31'h0, tmr5_clk_o}, {31'h0, c < 26});
        end
    endtask

    // Cut a hung run short
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        $display("MISMATCH run expected end seen hang");
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        test_reset();
        test_analog();
        test_output();
        test_change();
        test_pullup();
        test_timer();
        report_and_stop();
    end
endmodule
